// file: logic/pst_pkg.sv
// Package for the program space table access block.
// Assumes a single 40 MHz core clock and a 32-bit classic Wishbone bus.
package pst_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] PST_OFS_PAGE = 8'h00;
  localparam logic [7:0] PST_OFS_TADR_HI = 8'h04;
  localparam logic [7:0] PST_OFS_TADR_LO = 8'h08;
  localparam logic [7:0] PST_OFS_KEY = 8'h0C;
  // Reset values
  localparam logic [7:0] PST_RST_PAGE = 8'h00;
  localparam logic [7:0] PST_RST_TADR_HI = 8'h00;
  localparam logic [15:0] PST_RST_TADR_LO = 16'h0000;
  localparam logic [7:0] PST_RST_KEY = 8'h00;
  // Field positions
  localparam int PST_PAGE_CFG_BIT = 7;
  localparam int PST_BSEL_BIT = 0;
  // Program memory shape
  localparam int PST_WORD_W = 24;
  localparam int PST_MEM_AW = 10;
  localparam int PST_MEM_DEPTH = 1 << PST_MEM_AW;
  localparam logic [15:0] PST_PC_STEP = 16'h0002;
  typedef enum logic [1:0] {
    PST_IDLE = 2'b00,
    PST_READ = 2'b01,
    PST_DONE = 2'b10
  } pst_state_e;
endpackage

// file: logic/pst_mem_if.sv
// Interface between the table access engine and its program word store.
// Assumes both ends share clk_i.
`timescale 1ns/10ps
`default_nettype none
interface pst_mem_if;
  import pst_pkg::*;
  logic [PST_MEM_AW-1:0] addr;
  logic [2:0] wen;
  logic [PST_WORD_W-1:0] wdata;
  logic [PST_WORD_W-1:0] rdata;
  modport engine (output addr, output wen, output wdata, input rdata);
  modport store (input addr, input wen, input wdata, output rdata);
endinterface
`default_nettype wire

// file: logic/pst_pmem.sv
// Program word store: 24-bit words, one write enable per byte lane.
// Assumes synchronous reset; read data comes from a register.
`timescale 1ns/10ps
`default_nettype none
module pst_pmem
  import pst_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Engine side
  pst_mem_if.store mem
);
  wire [PST_WORD_W-1:0] rdata_w;

  // One byte-wide array and read register per lane
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lane
      logic [7:0] ram [PST_MEM_DEPTH];
      logic [7:0] rd_reg;
      always_ff @(posedge clk_i)
      begin
        if (mem.wen[g])
        begin
          ram[mem.addr] <= mem.wdata[g*8 +: 8];
        end
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          rd_reg <= 8'h00;
        end
        else
        begin
          rd_reg <= ram[mem.addr];
        end
      end
      assign rdata_w[g*8 +: 8] = rd_reg;
    end
  endgenerate

  assign mem.rdata = rdata_w;
endmodule
`default_nettype wire

// file: logic/pst_rdfmt.sv
// Formats a 24-bit program word onto the 16-bit data path.
// Assumes the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module pst_rdfmt
  import pst_pkg::*;
(
  // Request shape
  input wire logic high_i,
  input wire logic byte_i,
  input wire logic bsel_i,
  input wire logic [PST_WORD_W-1:0] word_i,
  // Result
  output logic [15:0] data_o
);
  always_comb
  begin
    case ({high_i, byte_i})
      2'b00: data_o = word_i[15:0];
      2'b01: data_o = {8'h00, bsel_i ? word_i[15:8] : word_i[7:0]};
      2'b10: data_o = {8'h00, word_i[23:16]};
      2'b11: data_o = {8'h00, bsel_i ? 8'h00 : word_i[23:16]};
      default: data_o = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// file: logic/pst_top.sv
// Program space table access: table reads and writes, page and target
// address registers, unlock key. Assumes one 40 MHz clock, sync reset,
// a classic Wishbone master and a core that holds each table request
// until it sees the acknowledge.
`timescale 1ns/10ps
`default_nettype none
module pst_top
  import pst_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core table port
  input wire logic tbl_req_i,
  input wire logic tbl_we_i,
  input wire logic tbl_high_i,
  input wire logic tbl_byte_i,
  input wire logic [15:0] tbl_addr_i,
  input wire logic [15:0] tbl_wdata_i,
  output logic tbl_ack_o,
  output logic [15:0] tbl_rdata_o,
  output logic [15:0] tbl_next_addr_o,
  // Flash controller side
  output logic [23:0] prog_target_o,
  output logic [7:0] unlock_key_o,
  output logic unlock_key_wr_o,
  output logic cfg_space_o
);
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] tadr_hi;
    logic [15:0] tadr_lo;
    logic [7:0] key;
    logic key_wr;
    logic wb_ack;
    logic [31:0] wb_dat;
    pst_state_e st;
    logic rd_high;
    logic rd_byte;
    logic rd_bsel;
    logic [15:0] rdata;
    logic [15:0] next_addr;
  } pst_regs_s;

  pst_regs_s r_reg;
  pst_regs_s r_next;
  pst_mem_if mif ();
  logic [15:0] fmt_data;
  logic wb_req;
  logic tbl_take;
  logic bsel;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [7:0] lane(input logic [7:0] old, input logic en,
                                      input logic [7:0] val);
    lane = en ? val : old;
  endfunction

  pst_pmem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mem (mif.store)
  );

  pst_rdfmt u_fmt (
    .high_i (r_reg.rd_high),
    .byte_i (r_reg.rd_byte),
    .bsel_i (r_reg.rd_bsel),
    .word_i (mif.rdata),
    .data_o (fmt_data)
  );

  assign wb_req = wb_cyc_i && wb_stb_i && !r_reg.wb_ack;
  assign tbl_take = tbl_req_i && (r_reg.st == PST_IDLE);
  assign bsel = tbl_addr_i[PST_BSEL_BIT];

  // Memory address and write lanes
  always_comb
  begin
    // Word index drops the byte select bit; page supplies the upper part
    mif.addr = {r_reg.page[PST_PAGE_CFG_BIT], r_reg.page[0],
                tbl_addr_i[8:1]};
    mif.wen = 3'b000;
    mif.wdata = {tbl_wdata_i[7:0],
                 tbl_byte_i ? {tbl_wdata_i[7:0], tbl_wdata_i[7:0]} : tbl_wdata_i};
    if (tbl_take && tbl_we_i)
    begin
      if (tbl_high_i)
      begin
        // Upper byte reachable only here; phantom byte writes are dropped
        mif.wen = {!(tbl_byte_i && bsel), 2'b00};
      end
      else if (tbl_byte_i)
      begin
        mif.wen = {1'b0, bsel, !bsel};
      end
      else
      begin
        mif.wen = 3'b011;
      end
    end
  end

  // Next state
  always_comb
  begin
    r_next = r_reg;
    r_next.key_wr = 1'b0;
    r_next.wb_ack = wb_req;
    if (wb_req)
    begin
      r_next.wb_dat = 32'h0000_0000;
      if (wb_we_i)
      begin
        if (hit(wb_adr_i, PST_OFS_PAGE))
        begin
          r_next.page = lane(r_reg.page, wb_sel_i[0], wb_dat_i[7:0]);
        end
        if (hit(wb_adr_i, PST_OFS_TADR_HI))
        begin
          r_next.tadr_hi = lane(r_reg.tadr_hi, wb_sel_i[0], wb_dat_i[7:0]);
        end
        if (hit(wb_adr_i, PST_OFS_TADR_LO))
        begin
          r_next.tadr_lo[7:0] = lane(r_reg.tadr_lo[7:0], wb_sel_i[0],
                                     wb_dat_i[7:0]);
          r_next.tadr_lo[15:8] = lane(r_reg.tadr_lo[15:8], wb_sel_i[1],
                                      wb_dat_i[15:8]);
        end
        if (hit(wb_adr_i, PST_OFS_KEY) && wb_sel_i[0])
        begin
          r_next.key = wb_dat_i[7:0];
          r_next.key_wr = 1'b1;
        end
      end
      else
      begin
        if (hit(wb_adr_i, PST_OFS_PAGE))
        begin
          r_next.wb_dat = {24'h000000, r_reg.page};
        end
        else if (hit(wb_adr_i, PST_OFS_TADR_HI))
        begin
          r_next.wb_dat = {24'h000000, r_reg.tadr_hi};
        end
        else if (hit(wb_adr_i, PST_OFS_TADR_LO))
        begin
          r_next.wb_dat = {16'h0000, r_reg.tadr_lo};
        end
        else
        begin
          // Key and unmapped offsets read as zero
          r_next.wb_dat = 32'h0000_0000;
        end
      end
    end
    case (r_reg.st)
      PST_IDLE:
      begin
        if (tbl_take)
        begin
          r_next.rd_high = tbl_high_i;
          r_next.rd_byte = tbl_byte_i;
          r_next.rd_bsel = bsel;
          r_next.next_addr = tbl_addr_i + PST_PC_STEP;
          r_next.st = tbl_we_i ? PST_DONE : PST_READ;
        end
      end
      PST_READ:
      begin
        r_next.rdata = fmt_data;
        r_next.st = PST_DONE;
      end
      PST_DONE:
      begin
        r_next.st = PST_IDLE;
      end
      default:
      begin
        r_next.st = PST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg.page <= PST_RST_PAGE;
      r_reg.tadr_hi <= PST_RST_TADR_HI;
      r_reg.tadr_lo <= PST_RST_TADR_LO;
      r_reg.key <= PST_RST_KEY;
      r_reg.key_wr <= 1'b0;
      r_reg.wb_ack <= 1'b0;
      r_reg.wb_dat <= 32'h0000_0000;
      r_reg.st <= PST_IDLE;
      r_reg.rd_high <= 1'b0;
      r_reg.rd_byte <= 1'b0;
      r_reg.rd_bsel <= 1'b0;
      r_reg.rdata <= 16'h0000;
      r_reg.next_addr <= 16'h0000;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.wb_ack;
  assign wb_dat_o = r_reg.wb_dat;
  assign tbl_ack_o = (r_reg.st == PST_DONE);
  assign tbl_rdata_o = r_reg.rdata;
  assign tbl_next_addr_o = r_reg.next_addr;
  assign prog_target_o = {r_reg.tadr_hi, r_reg.tadr_lo};
  assign unlock_key_o = r_reg.key;
  assign unlock_key_wr_o = r_reg.key_wr;
  assign cfg_space_o = r_reg.page[PST_PAGE_CFG_BIT];
endmodule
`default_nettype wire

// file: dv/pst_props.sv
// Checker on the table access block ports.
// Assumes one clock domain and the bind below.
`timescale 1ns/10ps
`default_nettype none
module pst_props
  import pst_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Table port
  input wire logic tbl_req_i,
  input wire logic tbl_we_i,
  input wire logic tbl_high_i,
  input wire logic tbl_byte_i,
  input wire logic [15:0] tbl_addr_i,
  input wire logic tbl_ack_o,
  input wire logic [15:0] tbl_rdata_o,
  input wire logic [15:0] tbl_next_addr_o,
  input wire logic unlock_key_wr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence tbl_start;
    $rose(tbl_req_i);
  endsequence
  sequence tbl_rd_done;
    tbl_ack_o && !tbl_we_i;
  endsequence
  wb_ack_next_a: assert property (wb_take |=> wb_ack_o)
    else $error("bus ack late");
  key_read_zero_a: assert property (wb_take ##0 (!wb_we_i && wb_adr_i == PST_OFS_KEY)
    |=> wb_dat_o == 32'h0) else $error("key readable");
  hi_upper_zero_a: assert property (wb_take ##0 (!wb_we_i && wb_adr_i == PST_OFS_TADR_HI)
    |=> wb_dat_o[31:8] == 24'h0) else $error("target high upper bits set");
  key_pulse_a: assert property (wb_take ##0 (wb_we_i && wb_adr_i == PST_OFS_KEY)
    |-> ##[1:2] unlock_key_wr_o) else $error("no key pulse");
  tbl_wr_ack_a: assert property (tbl_start ##0 tbl_we_i |=> tbl_ack_o)
    else $error("table write ack late");
  tbl_rd_ack_a: assert property (tbl_start ##0 !tbl_we_i |=> !tbl_ack_o ##1 tbl_ack_o)
    else $error("table read ack timing");
  high_word_a: assert property (tbl_rd_done ##0 (tbl_high_i && !tbl_byte_i)
    |-> tbl_rdata_o[15:8] == 8'h00) else $error("high word upper byte set");
  phantom_zero_a: assert property (tbl_rd_done ##0 (tbl_high_i && tbl_byte_i)
    ##0 tbl_addr_i[0] |-> tbl_rdata_o == 16'h0000) else $error("phantom byte not zero");
  pc_step_a: assert property (tbl_ack_o |-> tbl_next_addr_o == tbl_addr_i + PST_PC_STEP)
    else $error("next address wrong");
endmodule
bind pst_top pst_props i_props (
  .clk_i (clk_i),
  .rst_i (rst_i),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .tbl_req_i (tbl_req_i),
  .tbl_we_i (tbl_we_i),
  .tbl_high_i (tbl_high_i),
  .tbl_byte_i (tbl_byte_i),
  .tbl_addr_i (tbl_addr_i),
  .tbl_ack_o (tbl_ack_o),
  .tbl_rdata_o (tbl_rdata_o),
  .tbl_next_addr_o (tbl_next_addr_o),
  .unlock_key_wr_o (unlock_key_wr_o)
);
`default_nettype wire

// file: dv/pst_core_model.sv
// Core model issuing table reads and writes.
// Assumes the block acknowledges each held request.
`timescale 1ns/10ps
`default_nettype none
module pst_core_model (
  // Clock
  input wire logic clk_i,
  // Request
  output logic req_o,
  output logic we_o,
  output logic high_o,
  output logic byte_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  // Answer
  input wire logic ack_i,
  input wire logic [15:0] rdata_i
);
  initial {req_o, we_o, high_o, byte_o, addr_o, wdata_o} = '0;
  task automatic op(input logic we, input logic high, input logic bm,
                    input logic [15:0] adr, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_i);
    {req_o, we_o, high_o, byte_o, addr_o, wdata_o} <= {1'b1, we, high, bm, adr, wd};
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    rd = rdata_i;
    req_o <= 1'b0;
    addr_o <= ~adr;
    wdata_o <= ~wd;
  endtask
endmodule
`default_nettype wire

// file: dv/pst_top_tb.sv
// Self-checking bench for the table access block.
// Assumes checker and core model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module pst_top_tb;
  import pst_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, tbl_req_i, tbl_we_i, tbl_high_i, tbl_byte_i, tbl_ack_o;
  logic [15:0] tbl_addr_i, tbl_wdata_i, tbl_rdata_o, tbl_next_addr_o, rd16;
  logic [23:0] prog_target_o;
  logic [7:0] unlock_key_o;
  logic unlock_key_wr_o, cfg_space_o;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  pst_top i_dut (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .tbl_req_i (tbl_req_i),
    .tbl_we_i (tbl_we_i),
    .tbl_high_i (tbl_high_i),
    .tbl_byte_i (tbl_byte_i),
    .tbl_addr_i (tbl_addr_i),
    .tbl_wdata_i (tbl_wdata_i),
    .tbl_ack_o (tbl_ack_o),
    .tbl_rdata_o (tbl_rdata_o),
    .tbl_next_addr_o (tbl_next_addr_o),
    .prog_target_o (prog_target_o),
    .unlock_key_o (unlock_key_o),
    .unlock_key_wr_o (unlock_key_wr_o),
    .cfg_space_o (cfg_space_o)
  );
  pst_core_model i_core (.clk_i(clk_i), .req_o(tbl_req_i), .we_o(tbl_we_i),
    .high_o(tbl_high_i), .byte_o(tbl_byte_i), .addr_o(tbl_addr_i), .wdata_o(tbl_wdata_i),
    .ack_i(tbl_ack_o), .rdata_i(tbl_rdata_o));
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic test_regs;
    wb(1'b0, PST_OFS_TADR_HI, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, PST_OFS_TADR_HI, 32'hFFFF_FFA5);
    wb(1'b0, PST_OFS_TADR_HI, 32'h0);
    `CHK(rd, 32'h0000_00A5)
    wb(1'b1, PST_OFS_TADR_LO, 32'hFFFF_1234);
    wb(1'b0, PST_OFS_TADR_LO, 32'h0);
    `CHK(rd, 32'h0000_1234)
    `CHK(prog_target_o, 24'hA5_1234)
    wb_sel_i <= 4'h1;
    wb(1'b1, PST_OFS_TADR_LO, 32'hFFFF_5678);
    wb_sel_i <= 4'h3;
    wb(1'b0, PST_OFS_TADR_LO, 32'h0);
    `CHK(rd, 32'h0000_1278)
    wb(1'b1, PST_OFS_KEY, 32'h0000_FF5A);
    `CHK(unlock_key_o, 8'h5A)
    `CHK(unlock_key_wr_o, 1'b1)
    wb(1'b0, PST_OFS_KEY, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic test_table;
    logic [15:0] exp_t [6] = '{16'hBEEF, 16'h00EF, 16'h00BE, 16'h00C3, 16'h00C3, 16'h0000};
    wb(1'b1, PST_OFS_PAGE, 32'h0);
    i_core.op(1'b1, 1'b0, 1'b0, 16'h0004, 16'hBEEF, rd16);
    i_core.op(1'b1, 1'b1, 1'b0, 16'h0004, 16'hFFC3, rd16);
    for (int i = 0; i < 6; i++)
    begin
      i_core.op(1'b0, i > 2, i % 3 != 0, {15'h0002, i % 3 == 2}, 16'h0, rd16);
      `CHK(rd16, exp_t[i])
    end
    `CHK(tbl_next_addr_o, 16'h0005 + PST_PC_STEP)
    i_core.op(1'b1, 1'b0, 1'b1, 16'h0005, 16'hFF77, rd16);
    i_core.op(1'b0, 1'b0, 1'b0, 16'h0004, 16'h0, rd16);
    `CHK(rd16, 16'h77EF)
    i_core.op(1'b0, 1'b1, 1'b0, 16'h0004, 16'h0, rd16);
    `CHK(rd16, 16'h00C3)
  endtask
  task automatic test_page;
    wb(1'b1, PST_OFS_PAGE, 32'h0000_0080);
    `CHK(cfg_space_o, 1'b1)
    i_core.op(1'b1, 1'b0, 1'b0, 16'h0004, 16'h1111, rd16);
    i_core.op(1'b0, 1'b0, 1'b0, 16'h0004, 16'h0, rd16);
    `CHK(rd16, 16'h1111)
    wb(1'b1, PST_OFS_PAGE, 32'h0);
    `CHK(cfg_space_o, 1'b0)
    i_core.op(1'b0, 1'b0, 1'b0, 16'h0004, 16'h0, rd16);
    `CHK(rd16, 16'h77EF)
  endtask
  task automatic test_reset;
    wb(1'b1, PST_OFS_PAGE, 32'h0000_0080);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(prog_target_o, {PST_RST_TADR_HI, PST_RST_TADR_LO})
    `CHK(unlock_key_o, PST_RST_KEY)
    `CHK(cfg_space_o, PST_RST_PAGE[PST_PAGE_CFG_BIT])
    `CHK(tbl_rdata_o, 16'h0000)
    `CHK(tbl_next_addr_o, 16'h0000)
    wb(1'b0, PST_OFS_PAGE, 32'h0);
    `CHK(rd, {24'h00_0000, PST_RST_PAGE})
    i_core.op(1'b1, 1'b0, 1'b0, 16'h0008, 16'h4321, rd16);
    i_core.op(1'b0, 1'b0, 1'b0, 16'h0008, 16'h0, rd16);
    `CHK(rd16, 16'h4321)
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_table();
    test_page();
    test_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
